/* hw/srcr_regs.sv */
// soft reset and spi configuration register bank
//
// Contract
// - writing one to the soft reset bit resets the whole device and every register.
// - the soft reset waits until chip select is deasserted so the write completes.
// - the soft reset bit clears itself after being written.
// - the configuration synchronized bit is copied into every receive footer.
// - the synchronized bit is set by writing one, and writing zero never clears it.
// - after any reset sync is zero, the reset complete flag is one and the irq asserts.
// - with fcs check enabled the last four octets of each host frame are checked.
// - with cs alignment, frames start only at the first payload after cs assertion.
// - with zero alignment, each frame starts at a payload start with offset zero.
// - threshold codes 00, 01, 10 demand at least 1, 4, 8 free credits for the irq.
// - threshold code 11 demands at least 16 free credits.
module srcr_regs (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        csActive,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  input  wire logic        resetCompleteClear,
  input  wire logic [5:0]  txFreeCredits,
  input  wire logic        chunkProtocol,
  input  wire logic        rxFrameStartOk,
  input  wire logic        firstChunkAfterCs,
  output logic             deviceReset,
  output logic             resetCompleteFlag,
  output logic             footerSync,
  output logic             txFcsCheckEnable,
  output logic             rxFrameStartAllowed,
  output logic             frameStartWordOffsetZero,
  output logic             txCreditIrq,
  output logic             irqActive
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [5:0] creditNeed(input logic [1:0] code);
    case (code)
      2'b00:   creditNeed = srcr_pkg::CREDITS_CODE0;
      2'b01:   creditNeed = srcr_pkg::CREDITS_CODE1;
      2'b10:   creditNeed = srcr_pkg::CREDITS_CODE2;
      default: creditNeed = srcr_pkg::CREDITS_CODE3;
    endcase
  endfunction

  // ------------------------------------------------------------
  // soft reset sequencer
  // ------------------------------------------------------------
  srcr_pkg::srcr_state_type state;
  srcr_pkg::srcr_state_type next_state;
  logic softResetWrite;
  logic anyReset;

  assign softResetWrite = regWrite && regAddr == srcr_pkg::ADDR_SOFT_RESET
                          && regWdata[srcr_pkg::BIT_SOFT_RESET];
  assign anyReset       = reset || state == srcr_pkg::SRCR_RESET;
  assign deviceReset    = anyReset;

  // next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      srcr_pkg::SRCR_RUN:   if (softResetWrite) next_state = srcr_pkg::SRCR_ARMED;
      srcr_pkg::SRCR_ARMED: if (!csActive) next_state = srcr_pkg::SRCR_RESET;
      srcr_pkg::SRCR_RESET: next_state = srcr_pkg::SRCR_RUN;
      default:              next_state = srcr_pkg::SRCR_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) state <= srcr_pkg::SRCR_RUN;
    else       state <= next_state;
  end

  // ------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------
  logic       cfgSync;
  logic       cfgFcs;
  logic       cfgCsAlign;
  logic       cfgZeroAlign;
  logic [1:0] cfgThresh;
  logic [9:0] cfgLow;
  logic       cfgWrite;

  assign cfgWrite = regWrite && regAddr == srcr_pkg::ADDR_CONFIG_ZERO;

  // writable fields, all loaded from RESET_CONFIG_ZERO by either reset
  always_ff @(posedge clk_sys) begin
    if (anyReset) begin
      cfgSync      <= srcr_pkg::RESET_CONFIG_ZERO[srcr_pkg::BIT_CFG_SYNC];
      cfgFcs       <= srcr_pkg::RESET_CONFIG_ZERO[srcr_pkg::BIT_TX_FCS_CHECK];
      cfgCsAlign   <= srcr_pkg::RESET_CONFIG_ZERO[srcr_pkg::BIT_CS_ALIGN];
      cfgZeroAlign <= srcr_pkg::RESET_CONFIG_ZERO[srcr_pkg::BIT_ZERO_ALIGN];
      cfgThresh    <= srcr_pkg::RESET_CONFIG_ZERO[srcr_pkg::BIT_THRESH_HI:srcr_pkg::BIT_THRESH_LO];
      cfgLow       <= srcr_pkg::RESET_CONFIG_ZERO[9:0];
    end else if (cfgWrite) begin
      cfgSync      <= cfgSync | regWdata[srcr_pkg::BIT_CFG_SYNC];
      cfgFcs       <= regWdata[srcr_pkg::BIT_TX_FCS_CHECK];
      cfgCsAlign   <= regWdata[srcr_pkg::BIT_CS_ALIGN];
      cfgZeroAlign <= regWdata[srcr_pkg::BIT_ZERO_ALIGN];
      cfgThresh    <= regWdata[srcr_pkg::BIT_THRESH_HI:srcr_pkg::BIT_THRESH_LO];
      cfgLow       <= regWdata[9:0] & srcr_pkg::LOW_FIELD_MASK;
    end
  end

  // ------------------------------------------------------------
  // reset complete flag, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (anyReset)                resetCompleteFlag <= 1'b1;
    else if (resetCompleteClear) resetCompleteFlag <= 1'b0;
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (anyReset) begin
      regRdata <= srcr_pkg::RESET_SOFT_RESET;
    end else if (regRead && regAddr == srcr_pkg::ADDR_CONFIG_ZERO) begin
      regRdata <= {16'h0000, cfgSync, cfgFcs, cfgCsAlign, cfgZeroAlign, cfgThresh, cfgLow};
    end else if (regRead) begin
      regRdata <= srcr_pkg::RESET_SOFT_RESET;
    end
  end

  // ------------------------------------------------------------
  // outputs to datapaths and the interrupt pin
  // ------------------------------------------------------------
  assign footerSync       = cfgSync;
  assign txFcsCheckEnable = cfgFcs;
  // frame start gating for the receive path
  always_comb begin
    rxFrameStartAllowed      = rxFrameStartOk;
    frameStartWordOffsetZero = 1'b0;
    if (chunkProtocol && cfgCsAlign) begin
      rxFrameStartAllowed      = rxFrameStartOk && firstChunkAfterCs;
      frameStartWordOffsetZero = 1'b1;
    end else if (chunkProtocol && cfgZeroAlign) begin
      frameStartWordOffsetZero = 1'b1;
    end
  end
  assign txCreditIrq = chunkProtocol && txFreeCredits >= creditNeed(cfgThresh);
  assign irqActive   = resetCompleteFlag || txCreditIrq;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_armed;
    softResetWrite && state == srcr_pkg::SRCR_RUN;
  endsequence
  sequence s_wait_cs;
    state == srcr_pkg::SRCR_ARMED && csActive;
  endsequence

  a_reset_waits_cs: assert property (@(posedge clk_sys) disable iff (reset)
    s_armed ##1 csActive |-> !deviceReset)
    else $error("soft reset fired while chip select active");
  a_reset_after_cs: assert property (@(posedge clk_sys) disable iff (reset)
    state == srcr_pkg::SRCR_ARMED && !csActive |=> deviceReset)
    else $error("soft reset missing after chip select release");
  a_reset_self_clear: assert property (@(posedge clk_sys) disable iff (reset)
    deviceReset |=> state == srcr_pkg::SRCR_RUN)
    else $error("soft reset did not clear");
  a_reset_clears_sync: assert property (@(posedge clk_sys)
    deviceReset |=> !cfgSync && resetCompleteFlag && irqActive)
    else $error("post reset state wrong");
  a_sync_sticky: assert property (@(posedge clk_sys) disable iff (anyReset)
    cfgSync |=> cfgSync)
    else $error("sync bit cleared without reset");
  a_footer_sync: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(cfgSync) |-> footerSync && $past(cfgWrite))
    else $error("footer sync mismatch");
  a_zero_write_idle: assert property (@(posedge clk_sys) disable iff (reset)
    regWrite && regAddr == srcr_pkg::ADDR_SOFT_RESET && !regWdata[srcr_pkg::BIT_SOFT_RESET]
      && state == srcr_pkg::SRCR_RUN |=> state == srcr_pkg::SRCR_RUN)
    else $error("zero write armed reset");
  a_credit_irq16: assert property (@(posedge clk_sys) disable iff (reset)
    chunkProtocol && cfgThresh == 2'b11 && txFreeCredits < 6'h10 |-> !txCreditIrq)
    else $error("credit irq below sixteen");
  a_credit_irq4: assert property (@(posedge clk_sys) disable iff (reset)
    chunkProtocol && cfgThresh == 2'b01 |-> txCreditIrq == (txFreeCredits >= 6'h04))
    else $error("credit irq threshold four wrong");
  a_cs_align: assert property (@(posedge clk_sys) disable iff (reset)
    chunkProtocol && cfgCsAlign && !firstChunkAfterCs |-> !rxFrameStartAllowed)
    else $error("frame start outside first chunk");
  a_zero_offset: assert property (@(posedge clk_sys) disable iff (reset)
    chunkProtocol && cfgZeroAlign |-> frameStartWordOffsetZero)
    else $error("zero offset not forced");
  a_fcs_enable: assert property (@(posedge clk_sys) disable iff (anyReset)
    cfgWrite |=> txFcsCheckEnable == $past(regWdata[srcr_pkg::BIT_TX_FCS_CHECK]))
    else $error("fcs check enable not written");
  a_cs_wait_bound: assert property (@(posedge clk_sys) disable iff (reset)
    s_wait_cs ##1 !csActive |=> deviceReset)
    else $error("reset not issued after wait");

  // read side, flag priority and config defaults
  a_read_zero: assert property (@(posedge clk_sys) disable iff (anyReset)
    regRead && regAddr == srcr_pkg::ADDR_SOFT_RESET |=> regRdata == srcr_pkg::RESET_SOFT_RESET)
    else $error("soft reset register read not zero");
  a_flag_set_wins: assert property (@(posedge clk_sys)
    anyReset && resetCompleteClear |=> resetCompleteFlag)
    else $error("flag clear beat reset");
  a_cfg_defaults: assert property (@(posedge clk_sys)
    deviceReset |=> !cfgFcs && !cfgCsAlign && !cfgZeroAlign && cfgThresh == 2'b00)
    else $error("config fields not back at default");
  // threshold one and protocol gating
  a_credit_irq1: assert property (@(posedge clk_sys) disable iff (reset)
    chunkProtocol && cfgThresh == 2'b00 |-> txCreditIrq == (txFreeCredits >= 6'h01))
    else $error("credit irq threshold one wrong");
  a_no_chunk_irq: assert property (@(posedge clk_sys) disable iff (reset)
    !chunkProtocol |-> !txCreditIrq && !frameStartWordOffsetZero)
    else $error("chunk only feature active without chunk protocol");

endmodule

/* include/srcr_pkg.sv */
// constants for the soft reset and spi configuration register bank
package srcr_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  ADDR_SOFT_RESET   = 8'h03;
  localparam logic [7:0]  ADDR_CONFIG_ZERO  = 8'h04;
  // field positions in the soft reset and configuration registers
  localparam int          BIT_SOFT_RESET    = 0;
  localparam int          BIT_CFG_SYNC      = 15;
  localparam int          BIT_TX_FCS_CHECK  = 14;
  localparam int          BIT_CS_ALIGN      = 13;
  localparam int          BIT_ZERO_ALIGN    = 12;
  localparam int          BIT_THRESH_HI     = 11;
  localparam int          BIT_THRESH_LO     = 10;
  // reset values
  localparam logic [31:0] RESET_SOFT_RESET  = 32'h0000_0000;
  localparam logic [31:0] RESET_CONFIG_ZERO = 32'h0000_0006;
  // low bits [9:0] of the configuration register held verbatim here
  localparam logic [9:0]  LOW_FIELD_MASK    = 10'h3ff;
  // free credit counts per threshold code
  localparam logic [5:0]  CREDITS_CODE0     = 6'h01;
  localparam logic [5:0]  CREDITS_CODE1     = 6'h04;
  localparam logic [5:0]  CREDITS_CODE2     = 6'h08;
  localparam logic [5:0]  CREDITS_CODE3     = 6'h10;
  // least chip select time for the reset write
  localparam int          CS_MIN_NS         = 100;
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          CS_MIN_CYCLES     = (CS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // reset sequencer states
  typedef enum logic [2:0] {
    SRCR_RUN     = 3'b001,
    SRCR_ARMED   = 3'b010,
    SRCR_RESET   = 3'b100
  } srcr_state_type;
endpackage

/* sim/soft_reset_and_spi_config_regs_tb_top.sv */
// self-checking bench for the soft reset and spi configuration register bank
module soft_reset_and_spi_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, reset, resetCompleteClear, chunkProtocol, rxFrameStartOk;
  logic        firstChunkAfterCs, csActive, regWrite, regRead, pend, seen;
  logic        deviceReset, resetCompleteFlag, footerSync, txFcsCheckEnable;
  logic        rxFrameStartAllowed, frameStartWordOffsetZero, txCreditIrq, irqActive;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, w;
  logic [5:0]  txFreeCredits;
  logic [5:0]  needs [4];
  logic [31:0] expQ [$];
  int          fail_count, tests_run, seed;
  srcr_regs DUT (.clk_sys, .reset, .csActive, .regWrite, .regRead, .regAddr, .regWdata,
    .regRdata, .resetCompleteClear, .txFreeCredits, .chunkProtocol, .rxFrameStartOk,
    .firstChunkAfterCs, .deviceReset, .resetCompleteFlag, .footerSync, .txFcsCheckEnable,
    .rxFrameStartAllowed, .frameStartWordOffsetZero, .txCreditIrq, .irqActive);
  srcr_host_model host (.clk_sys, .csActive, .regWrite, .regRead, .regAddr, .regWdata);
  // 10 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a read notes its expected word; the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, a, 32'h0, 1'b0);
  endtask
  // read data stands in the cycle after the strobe is taken
  always @(negedge clk_sys) begin
    if (pend) begin
      if (expQ.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("regRdata", expQ.pop_front(), regRdata);
    end
    pend = regRead;
  end
  // hang guard, well past the roughly 120 cycles the run needs
  initial begin
    #(5000 * 100);
    fail_count++;
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset, resetCompleteClear, rxFrameStartOk, firstChunkAfterCs} = 4'h8;
    {chunkProtocol, txFreeCredits, pend, fail_count, tests_run} = {1'b1, 6'h00, 1'b0, 64'h0};
    seed = 32'hacf1;
    needs = '{srcr_pkg::CREDITS_CODE0, srcr_pkg::CREDITS_CODE1, srcr_pkg::CREDITS_CODE2,
      srcr_pkg::CREDITS_CODE3};
    repeat (5) @(posedge clk_sys);
    #1 reset = 1'b0;
    chk("reset flag", 1, resetCompleteFlag);
    chk("irq", 1, irqActive);
    rd(8'h04, srcr_pkg::RESET_CONFIG_ZERO);
    rd(8'h03, 32'h0);
    $display("reset values done");
    @(posedge clk_sys) #1 resetCompleteClear = 1'b1;
    @(posedge clk_sys) #1 resetCompleteClear = 1'b0;
    chk("flag clear", 0, resetCompleteFlag);
    w = $random(seed);
    w[15] = 1'b1;
    host.xfer(1'b1, 8'h04, w, 1'b0);
    chk("footer", 1, footerSync);
    w[15] = 1'b0;
    host.xfer(1'b1, 8'h04, w, 1'b0);
    chk("footer sticky", 1, footerSync);
    rd(8'h04, {16'h0, 1'b1, w[14:0]});
    $display("sync done");
    for (int m = 0; m < 8; m++) begin
      host.xfer(1'b1, 8'h04, {16'h0, 1'b0, 3'(m), 12'h006}, 1'b0);
      chk("fcs", m[2], txFcsCheckEnable);
      for (int f = 0; f < 2; f++) begin
        @(posedge clk_sys) #1 {rxFrameStartOk, firstChunkAfterCs} = {1'b1, 1'(f)};
        @(negedge clk_sys);
        chk("start", m[1] ? 1'(f) : 1'b1, rxFrameStartAllowed);
        chk("offset zero", m[1] | m[0], frameStartWordOffsetZero);
      end
    end
    $display("alignment done");
    for (int c = 0; c < 4; c++) begin
      host.xfer(1'b1, 8'h04, {20'h0, 2'(c), 10'h006}, 1'b0);
      for (int k = 0; k < 3; k++) begin
        @(posedge clk_sys) #1;
        txFreeCredits = (k == 2) ? 6'($random(seed)) : needs[c] - 6'(1 - k);
        @(negedge clk_sys);
        chk("credit irq", txFreeCredits >= needs[c], txCreditIrq);
        chk("irq", txFreeCredits >= needs[c], irqActive);
      end
      @(posedge clk_sys) #1 {chunkProtocol, txFreeCredits} = {1'b0, needs[c]};
      @(negedge clk_sys) chk("credit irq off", 0, txCreditIrq);
      @(posedge clk_sys) #1 chunkProtocol = 1'b1;
    end
    $display("threshold done");
    host.xfer(1'b1, 8'h03, 32'h0, 1'b0);
    repeat (3) @(negedge clk_sys) chk("zero write", 0, deviceReset);
    host.xfer(1'b1, 8'h03, 32'h1, 1'b1);
    repeat (3) @(negedge clk_sys) chk("early reset", 0, deviceReset);
    host.drop_cs();
    seen = 1'b0;
    repeat (4) @(negedge clk_sys) if (deviceReset === 1'b1) seen = 1'b1;
    chk("soft reset", 1, seen);
    chk("flag set", 1, resetCompleteFlag);
    chk("footer cleared", 0, footerSync);
    rd(8'h04, srcr_pkg::RESET_CONFIG_ZERO);
    rd(8'h03, 32'h0);
    repeat (3) @(negedge clk_sys) chk("no repeat", 0, deviceReset);
    $display("soft reset done");
    test_done();
  end
endmodule

/* sim/srcr_host_model.sv */
// spi host model that drives whole register words under chip select
module srcr_host_model (
  input  wire logic        clk_sys,
  output logic             csActive,
  output logic             regWrite,
  output logic             regRead,
  output logic [7:0]       regAddr,
  output logic [31:0]      regWdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    {csActive, regWrite, regRead, regAddr, regWdata} = '0;
  end
  // this host never turns on a mac crc append, so fcs check is safe to enable
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic hold);
    @(posedge clk_sys) #1;
    csActive = 1'b1;
    {regWrite, regRead, regAddr, regWdata} = {wr, ~wr, a, d};
    @(posedge clk_sys) #1;
    {regWrite, regRead, regAddr, regWdata} = {2'b00, ~a, ~d}; // released lines show inverse
    repeat (srcr_pkg::CS_MIN_CYCLES) @(posedge clk_sys); // cs stays past the strobe
    #1 csActive = hold;
  endtask
  // end a transaction left open by a held write
  task automatic drop_cs();
    @(posedge clk_sys) #1;
    csActive = 1'b0;
  endtask
endmodule
